// ---- core/ipv6_ext_pkg.sv ----
// Constants and state types for the IPv6 extension header receive and transmit paths
package ipv6_ext_pkg;
    localparam int         EXT_MAX_BYTES  = 176;
    localparam int         SETS_PER_PEER  = 4;
    localparam int         SET_W          = 2;
    localparam logic [3:0] VER_IPV4       = 4'h4;
    localparam logic [3:0] VER_IPV6       = 4'h6;
    localparam logic [11:0] POS_PLEN_HI   = 12'h004;
    localparam logic [11:0] POS_PLEN_LO   = 12'h005;
    localparam logic [11:0] POS_NEXT_HDR  = 12'h006;
    localparam logic [11:0] POS_BASE_LAST = 12'h027;
    localparam logic [11:0] EXT_LIMIT     = 12'h0B0;
    localparam logic [2:0]  HOLD_LAST     = 3'h6;
    localparam logic [7:0] NH_HOP_BY_HOP  = 8'h00;
    localparam logic [7:0] NH_UDP         = 8'h11;
    localparam logic [7:0] NH_L2TPV3      = 8'h73;
    localparam logic [7:0] NH_ROUTING     = 8'h2B;
    localparam logic [7:0] NH_FRAGMENT    = 8'h2C;
    localparam logic [7:0] NH_DEST_OPTS   = 8'h3C;
    localparam logic [7:0] EXT_MAX_LEN    = 8'hB0;
    localparam logic [7:0] CFG_ADDR_LEN   = 8'hB0;
    localparam logic [7:0] CFG_ADDR_FIRST = 8'hB1;
    localparam logic [7:0] CFG_ADDR_LAST  = 8'hB2;

    typedef enum logic [7:0] {
        R_VER    = 8'h01,
        R_V4     = 8'h02,
        R_V6     = 8'h04,
        R_REPLAY = 8'h08,
        R_SW     = 8'h10,
        R_EXT    = 8'h20,
        R_PAY    = 8'h40,
        R_DROP   = 8'h80
    } rx_state_t;

    typedef enum logic [3:0] {
        T_HDR  = 4'h1,
        T_PLEN = 4'h2,
        T_EXT  = 4'h4,
        T_PAY  = 4'h8
    } tx_state_t;
endpackage : ipv6_ext_pkg

// ---- core/pair_buffer.sv ----
// Two-entry valid/ready buffer with registered ready and valid
`timescale 1ns/1ps
`default_nettype none
module pair_buffer #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic         inValid,
    output logic              inReady,
    input  wire logic [W-1:0] inData,
    output logic              outValid,
    input  wire logic         outReady,
    output logic [W-1:0]      outData
);
    logic [W-1:0] slotQ [0:1];
    logic         wrPtrQ;
    logic         rdPtrQ;
    logic [1:0]   cntQ;
    logic [1:0]   cntD;
    logic         push;
    logic         pop;

    assign push    = inValid && inReady;
    assign pop     = outValid && outReady;
    assign outData = slotQ[rdPtrQ];

    always_comb begin
        cntD = cntQ;
        if (push && !pop) begin
            cntD = cntQ + 2'h1;
        end else if (pop && !push) begin
            cntD = cntQ - 2'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            slotQ[0] <= '0;
            slotQ[1] <= '0;
            wrPtrQ   <= 1'b0;
            rdPtrQ   <= 1'b0;
            cntQ     <= 2'h0;
            inReady  <= 1'b0;
            outValid <= 1'b0;
        end else begin
            if (push) begin
                slotQ[wrPtrQ] <= inData;
                wrPtrQ        <= ~wrPtrQ;
            end
            if (pop) begin
                rdPtrQ <= ~rdPtrQ;
            end
            cntQ     <= cntD;
            // Ready drops only when both slots hold a word
            inReady  <= (cntD != 2'h2);
            outValid <= (cntD != 2'h0);
        end
    end
endmodule : pair_buffer
`default_nettype wire

// ---- core/ipv6_ext_header_rx_tx.sv ----
// IPv6 extension header receive walker and transmit inserter for pseudowire data packets
// Operation
// - Carry IPv4 or IPv6 headers on receive; transmit edits every header as IPv6
// - Accept extension headers up to 176 bytes
// - Divert Hop-by-Hop packets whole to software
// - Find L2TPv3 by walking the header chain
// - Strip extension headers, ignore their contents
// - Insert up to 176 extension header bytes
// - Four header sets per headend core peer
// - Swap header sets atomically between packets
// - Header updates never stall the stream
`timescale 1ns/1ps
`default_nettype none
module ipv6_ext_header_rx_tx
    import ipv6_ext_pkg::*;
#(
    parameter int PEER_W = 1
) (
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic              rxInValid,
    output logic                   rxInReady,
    input  wire logic [7:0]        rxInData,
    input  wire logic              rxInLast,
    output logic                   rxOutValid,
    input  wire logic              rxOutReady,
    output logic [7:0]             rxOutData,
    output logic                   rxOutLast,
    output logic                   rxOutToSoftware,
    output logic                   rxHdrError,
    input  wire logic              txInValid,
    output logic                   txInReady,
    input  wire logic [7:0]        txInData,
    input  wire logic              txInLast,
    input  wire logic [PEER_W-1:0] txInPeer,
    input  wire logic [SET_W-1:0]  txInSet,
    output logic                   txOutValid,
    input  wire logic              txOutReady,
    output logic [7:0]             txOutData,
    output logic                   txOutLast,
    input  wire logic              cfgWrite,
    input  wire logic              cfgCommit,
    input  wire logic [PEER_W-1:0] cfgPeer,
    input  wire logic [SET_W-1:0]  cfgSet,
    input  wire logic [7:0]        cfgAddr,
    input  wire logic [7:0]        cfgData,
    output logic                   cfgBusy
);
    localparam int ENT_W   = PEER_W + SET_W;
    localparam int ENTRIES = 1 << ENT_W;
    localparam int SLOTS   = 2 * ENTRIES;
    localparam int TI_W    = 9 + ENT_W;

    // Receive side
    logic [8:0]  riWord;
    logic [9:0]  rxOutWord;
    logic        riValid;
    logic        riReady;
    logic        roValid;
    logic        roReady;
    logic [7:0]  roData;
    logic        roLast;
    logic        roSw;
    logic        rxTake;
    rx_state_t   rxStQ;
    logic [11:0] rxCntQ;
    logic [11:0] v4LenQ;
    logic [11:0] extLenQ;
    logic [11:0] extTotalQ;
    logic [11:0] extLenNext;
    logic [11:0] extSum;
    logic [7:0]  nhQ;
    logic [2:0]  repIdxQ;
    logic [7:0]  holdQ [0:6];
    logic        rxErrQ;

    pair_buffer #(.W(9)) rxInBuf (
        .clk      (clk),
        .rst_b    (rst_b),
        .inValid  (rxInValid),
        .inReady  (rxInReady),
        .inData   ({rxInLast, rxInData}),
        .outValid (riValid),
        .outReady (riReady),
        .outData  (riWord)
    );

    pair_buffer #(.W(10)) rxOutBuf (
        .clk      (clk),
        .rst_b    (rst_b),
        .inValid  (roValid),
        .inReady  (roReady),
        .inData   ({roSw, roLast, roData}),
        .outValid (rxOutValid),
        .outReady (rxOutReady),
        .outData  (rxOutWord)
    );

    assign rxOutData       = rxOutWord[7:0];
    assign rxOutLast       = rxOutWord[8];
    assign rxOutToSoftware = rxOutWord[9];
    assign rxHdrError      = rxErrQ;

    // Input waits while held bytes are replayed
    assign riReady    = roReady && (rxStQ != R_REPLAY);
    assign rxTake     = riValid && riReady;
    assign extLenNext = ({4'h0, riWord[7:0]} + 12'h001) << 3;
    assign extSum     = extTotalQ + extLenNext;

    function automatic rx_state_t rxRoute(input logic [7:0] nh);
        if (nh == NH_UDP || nh == NH_L2TPV3) begin
            return R_PAY;
        end else if (nh == NH_ROUTING || nh == NH_FRAGMENT || nh == NH_DEST_OPTS) begin
            return R_EXT;
        end
        return R_DROP;
    endfunction : rxRoute

    // only payload and diverted bytes leave
    always_comb begin
        roValid = 1'b0;
        roData  = riWord[7:0];
        roLast  = riWord[8];
        roSw    = (rxStQ == R_SW);
        unique case (rxStQ)
            R_REPLAY: begin
                roValid = roReady;
                roData  = holdQ[repIdxQ];
                roLast  = 1'b0;
                roSw    = 1'b1;
            end
            R_SW, R_PAY: begin
                roValid = riValid && roReady;
            end
            default: begin
                roValid = 1'b0;
            end
        endcase
    end

    // early bytes kept for a possible divert
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < 7; i++) begin
                holdQ[i] <= 8'h00;
            end
        end else if (rxTake && rxStQ == R_VER) begin
            holdQ[0] <= riWord[7:0];
        end else if (rxTake && rxStQ == R_V6 && rxCntQ <= POS_NEXT_HDR) begin
            holdQ[rxCntQ[2:0]] <= riWord[7:0];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rxStQ     <= R_VER;
            rxCntQ    <= 12'h000;
            v4LenQ    <= 12'h000;
            extLenQ   <= 12'h000;
            extTotalQ <= 12'h000;
            nhQ       <= 8'h00;
            repIdxQ   <= 3'h0;
            rxErrQ    <= 1'b0;
        end else begin
            rxErrQ <= 1'b0;
            unique case (rxStQ)
                // version nibble picks the header form
                R_VER: if (rxTake) begin
                    rxCntQ    <= 12'h001;
                    extTotalQ <= 12'h000;
                    if (riWord[8]) begin
                        rxErrQ <= 1'b1;
                    end else if (riWord[7:4] == VER_IPV4) begin
                        v4LenQ <= {6'h00, riWord[3:0], 2'b00};
                        rxStQ  <= R_V4;
                    end else if (riWord[7:4] == VER_IPV6) begin
                        rxStQ <= R_V6;
                    end else begin
                        rxStQ  <= R_DROP;
                        rxErrQ <= 1'b1;
                    end
                end
                R_V4: if (rxTake) begin
                    rxCntQ <= rxCntQ + 12'h001;
                    if (riWord[8]) begin
                        rxStQ  <= R_VER;
                        rxErrQ <= 1'b1;
                    end else if (rxCntQ == v4LenQ - 12'h001) begin
                        rxStQ <= R_PAY;
                    end
                end
                R_V6: if (rxTake) begin
                    rxCntQ <= rxCntQ + 12'h001;
                    if (rxCntQ == POS_NEXT_HDR) begin
                        nhQ <= riWord[7:0];
                    end
                    if (riWord[8]) begin
                        rxStQ  <= R_VER;
                        rxErrQ <= 1'b1;
                    end else if (rxCntQ == POS_NEXT_HDR && riWord[7:0] == NH_HOP_BY_HOP) begin
                        rxStQ   <= R_REPLAY;
                        repIdxQ <= 3'h0;
                    end else if (rxCntQ == POS_BASE_LAST) begin
                        rxStQ  <= rxRoute(nhQ);
                        rxErrQ <= (rxRoute(nhQ) == R_DROP);
                        rxCntQ <= 12'h000;
                    end
                end
                R_REPLAY: if (roReady) begin
                    if (repIdxQ == HOLD_LAST) begin
                        rxStQ <= R_SW;
                    end else begin
                        repIdxQ <= repIdxQ + 3'h1;
                    end
                end
                // each header length read from the packet
                R_EXT: if (rxTake) begin
                    rxCntQ <= rxCntQ + 12'h001;
                    if (rxCntQ == 12'h000) begin
                        nhQ <= riWord[7:0];
                    end
                    if (rxCntQ == 12'h001) begin
                        extLenQ   <= extLenNext;
                        extTotalQ <= extSum;
                    end
                    if (riWord[8]) begin
                        rxStQ  <= R_VER;
                        rxErrQ <= 1'b1;
                    // chains past the limit are dropped
                    end else if (rxCntQ == 12'h001 && extSum > EXT_LIMIT) begin
                        rxStQ  <= R_DROP;
                        rxErrQ <= 1'b1;
                    end else if (rxCntQ > 12'h001 && rxCntQ == extLenQ - 12'h001) begin
                        rxStQ  <= rxRoute(nhQ);
                        rxErrQ <= (rxRoute(nhQ) == R_DROP);
                        rxCntQ <= 12'h000;
                    end
                end
                R_SW, R_PAY, R_DROP: if (rxTake && riWord[8]) begin
                    rxStQ <= R_VER;
                end
                default: begin
                    rxStQ <= R_VER;
                end
            endcase
        end
    end

    // Transmit side
    logic [TI_W-1:0]  tiWord;
    logic [8:0]       txOutWord;
    logic             tiValid;
    logic             tiReady;
    logic             toValid;
    logic             toReady;
    logic [7:0]       toData;
    logic             toLast;
    logic             txTake;
    logic             txIdle;
    tx_state_t        txStQ;
    logic [11:0]      txCntQ;
    logic [7:0]       extIdxQ;
    logic [7:0]       plenHiQ;
    logic [7:0]       plenLoQ;
    logic [7:0]       origNhQ;
    logic [15:0]      plenSum;
    logic [ENT_W-1:0] selEntryQ;
    logic             selBankQ;
    logic [ENT_W-1:0] tiEntry;
    logic [ENT_W-1:0] cfgEntry;
    logic [ENT_W:0]   curSlot;
    logic [ENT_W:0]   wrSlot;
    logic [7:0]       curLen;
    logic [ENTRIES-1:0] activeQ;
    logic [ENTRIES-1:0] pendingQ;
    logic [ENTRIES-1:0] flipVec;
    logic [ENTRIES-1:0] commitVec;
    logic [ENTRIES-1:0] pendingD;
    logic             busyQ;
    // four sets per peer, each double banked
    logic [7:0]       extMemQ  [0:SLOTS-1][0:EXT_MAX_BYTES-1];
    logic [7:0]       setLenQ  [0:SLOTS-1];
    logic [7:0]       firstNhQ [0:SLOTS-1];
    logic [7:0]       lastIdxQ [0:SLOTS-1];

    pair_buffer #(.W(TI_W)) txInBuf (
        .clk      (clk),
        .rst_b    (rst_b),
        .inValid  (txInValid),
        .inReady  (txInReady),
        .inData   ({txInLast, txInPeer, txInSet, txInData}),
        .outValid (tiValid),
        .outReady (tiReady),
        .outData  (tiWord)
    );

    pair_buffer #(.W(9)) txOutBuf (
        .clk      (clk),
        .rst_b    (rst_b),
        .inValid  (toValid),
        .inReady  (toReady),
        .inData   ({toLast, toData}),
        .outValid (txOutValid),
        .outReady (txOutReady),
        .outData  (txOutWord)
    );

    assign txOutData = txOutWord[7:0];
    assign txOutLast = txOutWord[8];
    assign cfgBusy   = busyQ;
    assign tiEntry   = tiWord[8+ENT_W-1:8];
    assign cfgEntry  = {cfgPeer, cfgSet};
    assign curSlot   = {selEntryQ, selBankQ};
    assign wrSlot    = {cfgEntry, ~activeQ[cfgEntry]};
    assign curLen    = setLenQ[curSlot];
    assign plenSum   = {plenHiQ, tiWord[7:0]} + {8'h00, curLen};
    assign tiReady   = toReady && (txStQ == T_HDR || txStQ == T_PAY);
    assign txTake    = tiValid && tiReady;
    assign txIdle    = (txStQ == T_HDR) && (txCntQ == 12'h000);

    // swaps land between packets without a stall
    assign flipVec   = txIdle ? pendingQ : '0;
    assign commitVec = cfgCommit ? (ENTRIES'(1) << cfgEntry) : '0;
    assign pendingD  = commitVec | (pendingQ & ~flipVec);

    always_comb begin
        toValid = 1'b0;
        toData  = tiWord[7:0];
        toLast  = tiWord[TI_W-1];
        unique case (txStQ)
            T_HDR: begin
                toValid = tiValid && toReady && (txCntQ != POS_PLEN_HI);
                if (txCntQ == POS_PLEN_LO) begin
                    toData = plenSum[15:8];
                end else if (txCntQ == POS_NEXT_HDR && curLen != 8'h00) begin
                    toData = firstNhQ[curSlot];
                end
            end
            T_PLEN: begin
                toValid = toReady;
                toData  = plenLoQ;
                toLast  = 1'b0;
            end
            // stored set streamed after the base header
            T_EXT: begin
                toValid = toReady;
                toData  = (extIdxQ == lastIdxQ[curSlot]) ? origNhQ : extMemQ[curSlot][extIdxQ];
                toLast  = 1'b0;
            end
            T_PAY: begin
                toValid = tiValid && toReady;
            end
        endcase
    end

    // Memory has no reset; bytes below the set length are sent, written or not
    always_ff @(posedge clk) begin
        if (cfgWrite && cfgAddr < CFG_ADDR_LEN) begin
            extMemQ[wrSlot][cfgAddr] <= cfgData;
        end
    end

    // software fills the idle bank, commit flips it
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int s = 0; s < SLOTS; s++) begin
                setLenQ[s]  <= 8'h00;
                firstNhQ[s] <= 8'h00;
                lastIdxQ[s] <= 8'h00;
            end
            activeQ  <= '0;
            pendingQ <= '0;
            busyQ    <= 1'b0;
        end else begin
            if (cfgWrite && cfgAddr == CFG_ADDR_LEN) begin
                setLenQ[wrSlot] <= (cfgData > EXT_MAX_LEN) ? EXT_MAX_LEN : cfgData;
            end
            if (cfgWrite && cfgAddr == CFG_ADDR_FIRST) begin
                firstNhQ[wrSlot] <= cfgData;
            end
            if (cfgWrite && cfgAddr == CFG_ADDR_LAST) begin
                lastIdxQ[wrSlot] <= cfgData;
            end
            activeQ  <= activeQ ^ flipVec;
            pendingQ <= pendingD;
            busyQ    <= |pendingD;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            txStQ     <= T_HDR;
            txCntQ    <= 12'h000;
            extIdxQ   <= 8'h00;
            plenHiQ   <= 8'h00;
            plenLoQ   <= 8'h00;
            origNhQ   <= 8'h00;
            selEntryQ <= '0;
            selBankQ  <= 1'b0;
        end else begin
            unique case (txStQ)
                T_HDR: if (txTake) begin
                    txCntQ <= txCntQ + 12'h001;
                    // bank locked for the whole packet
                    if (txCntQ == 12'h000) begin
                        selEntryQ <= tiEntry;
                        selBankQ  <= activeQ[tiEntry] ^ pendingQ[tiEntry];
                    end
                    if (txCntQ == POS_PLEN_HI) begin
                        plenHiQ <= tiWord[7:0];
                    end
                    if (txCntQ == POS_NEXT_HDR) begin
                        origNhQ <= tiWord[7:0];
                    end
                    if (tiWord[TI_W-1]) begin
                        txCntQ <= 12'h000;
                    end else if (txCntQ == POS_PLEN_LO) begin
                        plenLoQ <= plenSum[7:0];
                        txStQ   <= T_PLEN;
                    end else if (txCntQ == POS_BASE_LAST) begin
                        extIdxQ <= 8'h00;
                        txStQ   <= (curLen != 8'h00) ? T_EXT : T_PAY;
                    end
                end
                T_PLEN: if (toReady) begin
                    txStQ <= T_HDR;
                end
                T_EXT: if (toReady) begin
                    if (extIdxQ == curLen - 8'h01) begin
                        txStQ <= T_PAY;
                    end else begin
                        extIdxQ <= extIdxQ + 8'h01;
                    end
                end
                T_PAY: if (txTake && tiWord[TI_W-1]) begin
                    txStQ  <= T_HDR;
                    txCntQ <= 12'h000;
                end
            endcase
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence sPlenSplit;
        txStQ == T_HDR && txTake && txCntQ == POS_PLEN_LO && !tiWord[TI_W-1];
    endsequence

    chk_rx_version_pick: assert property (rxStQ == R_VER && rxTake && !riWord[8] && riWord[7:4] == VER_IPV4 |=> rxStQ == R_V4) else $error("IPv4 not taken");
    chk_rx_hbh_divert: assert property (rxStQ == R_V6 && rxTake && rxCntQ == POS_NEXT_HDR && !riWord[8] && riWord[7:0] == NH_HOP_BY_HOP |=> rxStQ == R_REPLAY && repIdxQ == 3'h0) else $error("Hop-by-Hop not diverted");
    chk_rx_replay_end: assert property (rxStQ == R_REPLAY && roReady && repIdxQ == HOLD_LAST |-> roSw && roValid ##1 rxStQ == R_SW) else $error("Replay did not end in software pass");
    chk_rx_ext_limit: assert property (rxStQ == R_EXT && rxTake && rxCntQ == 12'h001 && !riWord[8] && extSum > EXT_LIMIT |=> rxStQ == R_DROP && rxHdrError) else $error("Oversize chain not dropped");
    chk_rx_chain_walk: assert property (rxStQ == R_EXT && rxTake && !riWord[8] && rxCntQ > 12'h001 && rxCntQ == extLenQ - 12'h001 && (nhQ == NH_UDP || nhQ == NH_L2TPV3) |=> rxStQ == R_PAY && rxCntQ == 12'h000) else $error("Walk missed L2TPv3 start");
    chk_rx_hdr_strip: assert property (roValid && !roSw |-> rxStQ == R_PAY) else $error("Header byte on hardware path");
    chk_tx_plen_split: assert property (sPlenSplit |-> toValid && toData == plenSum[15:8] ##1 txStQ == T_PLEN && plenLoQ == $past(plenSum[7:0])) else $error("Payload length not adjusted");
    chk_tx_bank_locked: assert property (txStQ == T_EXT && cfgWrite |-> wrSlot != curSlot) else $error("Active header set being written");
    chk_tx_swap_prompt: assert property (txIdle && pendingQ != '0 && !cfgCommit |=> pendingQ == '0 && !cfgBusy) else $error("Pending swap held back");
endmodule : ipv6_ext_header_rx_tx
`default_nettype wire

// ---- tb/far_sink.sv ----
// Far-side sink that stalls now and then and records every accepted word
`timescale 1ns/1ps
`default_nettype none
module far_sink (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       valid,
    input  wire logic [9:0] data,
    output logic            ready
);
    logic [1:0] phase_q;
    logic [9:0] got[$];
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            phase_q <= 2'h0;
        end else begin
            phase_q <= phase_q + 2'h1;
            if (valid && ready) begin
                got.push_back(data);
            end
        end
    end
    // Stall one cycle in four, so a lost word shows
    assign ready = phase_q != 2'h3;
endmodule : far_sink
`default_nettype wire

// ---- tb/ipv6_ext_header_rx_tx_bench.sv ----
// Bench for the IPv6 extension header receive and transmit paths
`timescale 1ns/1ps
`default_nettype none
module ipv6_ext_header_rx_tx_bench;
    import ipv6_ext_pkg::*;
    logic             clk = 1'b0, rst_b = 1'b0, cfgWrite = 1'b0, cfgCommit = 1'b0;
    logic             rxInValid = 1'b0, rxInLast = 1'b0, txInValid = 1'b0, txInLast = 1'b0;
    logic [7:0]       rxInData = 8'h00, txInData = 8'h00, cfgAddr = 8'h00, cfgData = 8'h00;
    logic             cfgPeer = 1'b0, txInPeer = 1'b0;
    logic [SET_W-1:0] cfgSet = 2'h0, txInSet = 2'h0;
    logic             rxInReady, rxOutValid, rxOutReady, rxOutLast, rxOutToSoftware, rxHdrError;
    logic             txInReady, txOutValid, txOutReady, txOutLast, cfgBusy;
    logic [7:0]       rxOutData, txOutData;
    logic [9:0]       e[$];
    logic [7:0]       p[$];
    int               miscompares = 0, total_checks = 0, hdrErrSeen = 0, hdrErrWant = 0;
    ipv6_ext_header_rx_tx dut (.*);
    far_sink rxSink (.clk(clk), .rst_b(rst_b), .valid(rxOutValid),
        .data({rxOutLast, rxOutToSoftware, rxOutData}), .ready(rxOutReady));
    far_sink txSink (.clk(clk), .rst_b(rst_b), .valid(txOutValid),
        .data({txOutLast, 1'b0, txOutData}), .ready(txOutReady));
    initial forever #5 clk = ~clk;
    // Error is a one-cycle pulse, so count it off the edge
    always @(negedge clk) if (rxHdrError === 1'b1) hdrErrSeen++;
    task automatic end_of_test;
        if (miscompares == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_of_test
    task automatic check(input logic [9:0] g, input logic [9:0] x);
        total_checks++;
        if (g !== x) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, g, x);
        end
    endtask : check
    task automatic send(input bit tx);
        foreach (p[i]) begin
            @(negedge clk);
            if (tx) {txInValid, txInLast, txInData} = {1'b1, i == p.size() - 1, p[i]};
            else {rxInValid, rxInLast, rxInData} = {1'b1, i == p.size() - 1, p[i]};
            while ((tx ? txInReady : rxInReady) !== 1'b1) @(negedge clk);
        end
        @(negedge clk);
        {txInValid, rxInValid} = 2'h0;
    endtask : send
    task automatic expect_out(input bit tx, input int errs);
        for (int n = 0; n < 2000 && (tx ? txSink.got.size() : rxSink.got.size()) < e.size(); n++) @(negedge clk);
        // Extra wait so surplus words are caught too
        repeat (20) @(negedge clk);
        foreach (e[i]) check(tx ? txSink.got[i] : rxSink.got[i], e[i]);
        check(10'(tx ? txSink.got.size() : rxSink.got.size()), 10'(e.size()));
        hdrErrWant += errs;
        check(10'(hdrErrSeen), 10'(hdrErrWant));
        rxSink.got.delete();
        txSink.got.delete();
        e.delete();
        p.delete();
    endtask : expect_out
    task automatic wr(input logic pr, input logic [SET_W-1:0] s, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        {cfgWrite, cfgPeer, cfgSet, cfgAddr, cfgData} = {1'b1, pr, s, a, d};
    endtask : wr
    task automatic rx_v6_chain;
        p = {8'h60, 8'h00, 8'h00, 8'h00, 8'h00, 8'hB3, NH_ROUTING, 8'h40};
        repeat (32) p.push_back(8'h00);
        p = {p, NH_UDP, 8'h15};
        repeat (174) p.push_back(8'h5A);
        p = {p, 8'hA1, 8'hA2, 8'hA3};
        e = {10'h0A1, 10'h0A2, 10'h2A3};
        send(1'b0);
        expect_out(1'b0, 0);
    endtask : rx_v6_chain
    task automatic rx_v4;
        p = {8'h45, 8'h00, 8'h00, 8'h17};
        repeat (5) p.push_back(8'h00);
        p.push_back(NH_UDP);
        repeat (10) p.push_back(8'h00);
        p = {p, 8'hB1, 8'hB2, 8'hB3};
        e = {10'h0B1, 10'h0B2, 10'h2B3};
        send(1'b0);
        expect_out(1'b0, 0);
    endtask : rx_v4
    task automatic rx_drop;
        p = {8'h60, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08, NH_ROUTING, 8'h40};
        repeat (32) p.push_back(8'h00);
        p = {p, NH_UDP, 8'h16, 8'h5A, 8'h5A};
        send(1'b0);
        p = {8'h50, 8'hE1, 8'hE2};
        send(1'b0);
        expect_out(1'b0, 2);
    endtask : rx_drop
    task automatic rx_hop;
        p = {8'h60, 8'h00, 8'h00, 8'h00, 8'h00, 8'h09, NH_HOP_BY_HOP, 8'h40};
        repeat (32) p.push_back(8'h00);
        p = {p, NH_UDP, 8'h00};
        repeat (6) p.push_back(8'h00);
        p.push_back(8'hC1);
        foreach (p[i]) e.push_back({i == p.size() - 1, 1'b1, p[i]});
        send(1'b0);
        expect_out(1'b0, 0);
    endtask : rx_hop
    task automatic tx_insert(input logic pr, input logic [SET_W-1:0] s);
        logic [7:0] b;
        // Set bytes differ per entry, so a wrong entry shows
        b = {1'b0, pr, s, 4'h0};
        wr(pr, s, CFG_ADDR_LEN, 8'h08);
        wr(pr, s, CFG_ADDR_FIRST, NH_ROUTING);
        wr(pr, s, CFG_ADDR_LAST, 8'h00);
        for (int k = 0; k < 8; k++) wr(pr, s, 8'(k), b + 8'(k));
        @(negedge clk);
        {cfgWrite, cfgCommit} = 2'h1;
        @(negedge clk);
        cfgCommit = 1'b0;
        check(10'(cfgBusy), 10'h001);
        for (int n = 0; n < 100 && cfgBusy !== 1'b0; n++) @(negedge clk);
        check(10'(cfgBusy), 10'h000);
        {txInPeer, txInSet} = {pr, s};
        p = {8'h60, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, NH_UDP, 8'h40};
        repeat (32) p.push_back(8'h00);
        p = {p, 8'hD1, 8'hD2};
        foreach (p[i]) begin
            if (i == 40) begin
                e.push_back({2'h0, NH_UDP});
                for (int k = 1; k < 8; k++) e.push_back({2'h0, b + 8'(k)});
            end
            e.push_back({i == p.size() - 1, 1'b0, i == 5 ? 8'h0A : i == 6 ? NH_ROUTING : p[i]});
        end
        send(1'b1);
        expect_out(1'b1, 0);
    endtask : tx_insert
    initial begin
        repeat (10) @(negedge clk);
        rst_b = 1'b1;
        repeat (2) @(negedge clk);
        rx_v6_chain();
        rx_v4();
        rx_hop();
        rx_drop();
        tx_insert(1'b1, 2'h3);
        tx_insert(1'b0, 2'h1);
        end_of_test();
    end
    // Whole run is under a thousand cycles
    initial begin
        #200us;
        miscompares++;
        end_of_test();
    end
endmodule : ipv6_ext_header_rx_tx_bench
`default_nettype wire
